// File: verilog/sfc_pkg.sv
// Constants and types of the serial flash command engine.
// Assumes a mode 0 SPI host and a system clock of 250 MHz.

package sfc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int MEM_AW = 17;
    localparam int MEM_BYTES = 1 << MEM_AW;
    localparam logic [MEM_AW-1:0] PAGE_MASK = 17'h000ff;
    localparam logic [MEM_AW-1:0] SECTOR_MASK = 17'h00fff;
    localparam logic [MEM_AW-1:0] BLOCK_MASK = 17'h0ffff;
    localparam logic [MEM_AW-1:0] CHIP_MASK = 17'h1ffff;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_UNLOCK = 8'h06;
    localparam logic [7:0] OP_DUAL_RD = 8'h3b;
    localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
    localparam logic [7:0] OP_LARGE_WIPE = 8'hd8;
    localparam logic [7:0] OP_FULL_WIPE = 8'hc7;
    localparam logic [7:0] OP_PAGE_WR = 8'h02;
    localparam logic [7:0] OP_SLEEP = 8'hb9;
    localparam logic [7:0] OP_WAKE_SIG = 8'hab;

    // Signature byte, arbitrary value
    localparam logic [7:0] SIGNATURE = 8'h5a;

    // ------------------------------------------------------------------
    // Frame bit counts
    // ------------------------------------------------------------------
    localparam logic [5:0] OP_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h20;
    localparam logic [5:0] DUAL_RD_BITS = 6'h28;
    localparam logic [5:0] PAGE_WR_MIN_BITS = 6'h28;
    localparam logic [5:0] SIG_MIN_BITS = 6'h28;
    localparam logic [5:0] BITS_SAT = 6'h3f;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_NS = 8800;
    localparam logic [11:0] SLEEP_ENTRY_CYC =
        12'((SLEEP_ENTRY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [11:0] WAKE_CYC =
        12'((WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WIPE,
        ST_PROG,
        ST_SLEEP_WAIT,
        ST_SLEEP,
        ST_WAKE
    } sfc_state_e;

endpackage

// File: verilog/sfc_cmd_engine.sv
// Command engine of a serial NOR flash slave with its own array.
// Assumes a mode 0 SPI host; SCLK stops while chip select is high.

`timescale 1ns/10ps

module sfc_cmd_engine (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sio0,
    input wire logic i_sio1,
    output logic o_sio0,
    output logic o_sio0_oe_n,
    output logic o_sio1,
    output logic o_sio1_oe_n,
    input wire logic i_protect_level_hi,
    input wire logic i_protect_level_lo,
    output logic o_busy_flag,
    output logic o_write_unlock_latch,
    output logic o_deep_sleep
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    // Array written on i_clock only; link side reads it while idle
    logic [7:0] mem [0:sfc_pkg::MEM_BYTES-1];
    // Page buffer written on i_sclk only; core reads it while busy
    logic [7:0] pbuf [0:255];
    logic [255:0] pvalid;

    // Protection: level 1 top quarter, 2 top half, 3 everything
    function automatic logic prot(input logic [sfc_pkg::MEM_AW-1:0] a,
                                  input logic [1:0] bp);
        logic p;
        p = 1'b0;
        case (bp)
            2'h1: p = &a[sfc_pkg::MEM_AW-1:sfc_pkg::MEM_AW-2];
            2'h2: p = a[sfc_pkg::MEM_AW-1];
            2'h3: p = 1'b1;
            default: p = 1'b0;
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------------
    // Link domain (SCLK); frame decode and pins cleared by chip select high
    // ------------------------------------------------------------------
    logic [7:0] op;
    logic [5:0] bits;
    logic [2:0] phase;
    logic [23:0] addr;
    logic [6:0] shreg;
    logic [7:0] wr_idx;
    logic [1:0] pair;
    logic [2:0] sig_bit;
    logic [sfc_pkg::MEM_AW-1:0] rd_addr;
    logic rd_run;
    logic busy_m;
    logic busy_s;
    logic sleep_m;
    logic sleep_s;
    logic [7:0] next_op;
    logic dual_ok;
    logic page_cap;
    logic [7:0] f_op;
    logic [5:0] f_bits;
    logic [2:0] f_phase;
    logic [23:0] f_word;
    logic [sfc_pkg::MEM_AW-1:0] cur;
    logic [7:0] rd_byte;

    assign next_op = {op[6:0], i_sio0};
    // Dual mode only for the dual read opcode, never while busy or asleep
    assign dual_ok = (op == sfc_pkg::OP_DUAL_RD) && !busy_s && !sleep_s;
    assign page_cap = (op == sfc_pkg::OP_PAGE_WR) && (bits >= sfc_pkg::ADDR_BITS)
                      && !busy_s && !sleep_s;
    assign cur = rd_run ? rd_addr : addr[sfc_pkg::MEM_AW-1:0];
    assign rd_byte = mem[cur];

    // Frame snapshot on select rise; the async clear would otherwise wipe it
    always_ff @(posedge i_cs_n) begin
        f_op <= op;
        f_bits <= bits;
        f_phase <= phase;
        f_word <= addr;
    end

    // Core state levels into the link domain; 8 opcode edges cover it
    always_ff @(posedge i_sclk) begin
        busy_m <= o_busy_flag;
        busy_s <= busy_m;
        sleep_m <= o_deep_sleep;
        sleep_s <= sleep_m;
    end

    // Opcode, address and bit count on rising SCLK
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            op <= 8'h00;
            bits <= 6'h00;
            phase <= 3'h0;
            addr <= 24'h000000;
        end else begin
            phase <= phase + 3'h1;
            if (bits < sfc_pkg::OP_BITS) begin
                op <= next_op;
            end else if (bits < sfc_pkg::ADDR_BITS) begin
                if (dual_ok) begin
                    addr <= {addr[21:0], i_sio1, i_sio0};
                end else begin
                    addr <= {addr[22:0], i_sio0};
                end
            end
            // Dual address and dummy advance two bits an edge
            if (bits >= sfc_pkg::OP_BITS && dual_ok) begin
                bits <= (bits >= sfc_pkg::BITS_SAT - 6'h01) ?
                        sfc_pkg::BITS_SAT : bits + 6'h02;
            end else if (bits != sfc_pkg::BITS_SAT) begin
                bits <= bits + 6'h01;
            end
        end
    end

    // Page data capture; index wraps inside the page
    always_ff @(posedge i_sclk) begin
        shreg <= {shreg[5:0], i_sio0};
        if (bits == sfc_pkg::ADDR_BITS - 6'h01) begin
            wr_idx <= {addr[6:0], i_sio0};
        end else if (page_cap && phase == 3'h7) begin
            wr_idx <= wr_idx + 8'h01;
        end
        if (page_cap && phase == 3'h7) begin
            pbuf[wr_idx] <= {shreg, i_sio0};
        end
    end

    // Byte valid map; untouched bytes are skipped when programming
    always_ff @(posedge i_sclk) begin
        if (bits == sfc_pkg::OP_BITS - 6'h01 && next_op == sfc_pkg::OP_PAGE_WR
            && !busy_s) begin
            pvalid <= '0;
        end else if (page_cap && phase == 3'h7) begin
            pvalid[wr_idx] <= 1'b1;
        end
    end

    // Output pins on falling SCLK; released while chip select is high
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_sio0 <= 1'b0;
            o_sio1 <= 1'b0;
            o_sio0_oe_n <= 1'b1;
            o_sio1_oe_n <= 1'b1;
            pair <= 2'h0;
            sig_bit <= 3'h0;
            rd_addr <= '0;
            rd_run <= 1'b0;
        end else if (dual_ok && bits >= sfc_pkg::DUAL_RD_BITS) begin
            o_sio1 <= rd_byte[{~pair, 1'b1}];
            o_sio0 <= rd_byte[{~pair, 1'b0}];
            o_sio0_oe_n <= 1'b0;
            o_sio1_oe_n <= 1'b0;
            pair <= pair + 2'h1;
            rd_run <= 1'b1;
            // Counter width equals the array, so the top wraps to zero
            rd_addr <= (pair == 2'h3) ? cur + 1'b1 : cur;
        end else if (op == sfc_pkg::OP_WAKE_SIG && bits >= sfc_pkg::ADDR_BITS
                     && !busy_s) begin
            o_sio1 <= sfc_pkg::SIGNATURE[~sig_bit];
            o_sio1_oe_n <= 1'b0;
            sig_bit <= sig_bit + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Core domain (i_clock)
    // ------------------------------------------------------------------
    logic cs_m;
    logic cs_s;
    logic cs_q;
    logic frame_end;
    sfc_pkg::sfc_state_e state;
    logic [sfc_pkg::MEM_AW-1:0] idx;
    logic [sfc_pkg::MEM_AW-1:0] mask;
    logic [sfc_pkg::MEM_AW-1:0] base;
    logic [11:0] dly;
    logic [1:0] bp;
    logic [sfc_pkg::MEM_AW-1:0] f_addr;
    logic idle_end;
    logic acc_unlock;
    logic acc_small;
    logic acc_large;
    logic acc_full;
    logic acc_page;
    logic acc_sleep;
    logic acc_wake;
    logic op_done;

    // Chip select synchroniser and rise detect
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_q <= 1'b1;
        end else begin
            cs_m <= i_cs_n;
            cs_s <= cs_m;
            cs_q <= cs_s;
        end
    end

    // Snapshot words are static from select rise, well before the sync sees it
    assign frame_end = cs_s && !cs_q;
    assign bp = {i_protect_level_hi, i_protect_level_lo};
    assign f_addr = f_word[sfc_pkg::MEM_AW-1:0];
    // Commands other than wake decode only in standby; busy and sleep ignore them
    assign idle_end = frame_end && (state == sfc_pkg::ST_IDLE);

    // Acceptance of each command at the end of its frame
    assign acc_unlock = idle_end && f_op == sfc_pkg::OP_UNLOCK
                        && f_bits == sfc_pkg::OP_BITS;
    assign acc_small = idle_end && o_write_unlock_latch
                       && f_op == sfc_pkg::OP_SMALL_WIPE
                       && f_bits == sfc_pkg::ADDR_BITS
                       && !prot(f_addr | sfc_pkg::SECTOR_MASK, bp);
    assign acc_large = idle_end && o_write_unlock_latch
                       && f_op == sfc_pkg::OP_LARGE_WIPE
                       && f_bits == sfc_pkg::ADDR_BITS
                       && !prot(f_addr | sfc_pkg::BLOCK_MASK, bp);
    assign acc_full = idle_end && o_write_unlock_latch
                      && f_op == sfc_pkg::OP_FULL_WIPE
                      && f_bits == sfc_pkg::OP_BITS
                      && bp == 2'h0;
    assign acc_page = idle_end && o_write_unlock_latch
                      && f_op == sfc_pkg::OP_PAGE_WR
                      && f_bits >= sfc_pkg::PAGE_WR_MIN_BITS
                      && f_phase == 3'h0
                      && !prot(f_addr | sfc_pkg::PAGE_MASK, bp);
    assign acc_sleep = idle_end && f_op == sfc_pkg::OP_SLEEP
                       && f_bits == sfc_pkg::OP_BITS;
    // Wake needs an exact opcode; signature read needs one whole byte out
    assign acc_wake = frame_end && (state == sfc_pkg::ST_SLEEP)
                      && f_op == sfc_pkg::OP_WAKE_SIG
                      && (f_bits == sfc_pkg::OP_BITS
                          || f_bits >= sfc_pkg::SIG_MIN_BITS);
    assign op_done = (state == sfc_pkg::ST_WIPE || state == sfc_pkg::ST_PROG)
                     && idx == mask;

    // Sequencer: wipe and program step one byte a clock
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state <= sfc_pkg::ST_IDLE;
            idx <= '0;
            mask <= '0;
            base <= '0;
            dly <= 12'h000;
        end else begin
            case (state)
                sfc_pkg::ST_IDLE: begin
                    idx <= '0;
                    if (acc_small) begin
                        state <= sfc_pkg::ST_WIPE;
                        mask <= sfc_pkg::SECTOR_MASK;
                        base <= f_addr & ~sfc_pkg::SECTOR_MASK;
                    end else if (acc_large) begin
                        state <= sfc_pkg::ST_WIPE;
                        mask <= sfc_pkg::BLOCK_MASK;
                        base <= f_addr & ~sfc_pkg::BLOCK_MASK;
                    end else if (acc_full) begin
                        state <= sfc_pkg::ST_WIPE;
                        mask <= sfc_pkg::CHIP_MASK;
                        base <= '0;
                    end else if (acc_page) begin
                        state <= sfc_pkg::ST_PROG;
                        mask <= sfc_pkg::PAGE_MASK;
                        base <= f_addr & ~sfc_pkg::PAGE_MASK;
                    end else if (acc_sleep) begin
                        state <= sfc_pkg::ST_SLEEP_WAIT;
                        dly <= sfc_pkg::SLEEP_ENTRY_CYC;
                    end
                end
                sfc_pkg::ST_WIPE, sfc_pkg::ST_PROG: begin
                    idx <= idx + 1'b1;
                    if (idx == mask) begin
                        state <= sfc_pkg::ST_IDLE;
                    end
                end
                sfc_pkg::ST_SLEEP_WAIT: begin
                    dly <= dly - 12'h001;
                    if (dly == 12'h001) begin
                        state <= sfc_pkg::ST_SLEEP;
                    end
                end
                sfc_pkg::ST_SLEEP: begin
                    if (acc_wake) begin
                        state <= sfc_pkg::ST_WAKE;
                        dly <= sfc_pkg::WAKE_CYC;
                    end
                end
                sfc_pkg::ST_WAKE: begin
                    dly <= dly - 12'h001;
                    if (dly == 12'h001) begin
                        state <= sfc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= sfc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Array update: erase to ones, program only clears bits
    always_ff @(posedge i_clock) begin
        if (state == sfc_pkg::ST_WIPE) begin
            mem[base | idx] <= 8'hff;
        end else if (state == sfc_pkg::ST_PROG && pvalid[idx[7:0]]) begin
            mem[base | idx] <= mem[base | idx] & pbuf[idx[7:0]];
        end
    end

    // Busy flag spans the whole self-timed cycle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_busy_flag <= 1'b0;
        end else if (acc_small || acc_large || acc_full || acc_page) begin
            o_busy_flag <= 1'b1;
        end else if (op_done) begin
            o_busy_flag <= 1'b0;
        end
    end

    // Unlock latch; completion clears it so each write needs a new unlock
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_write_unlock_latch <= 1'b0;
        end else if (acc_unlock) begin
            o_write_unlock_latch <= 1'b1;
        end else if (op_done) begin
            o_write_unlock_latch <= 1'b0;
        end
    end

    // Deep sleep flag
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_deep_sleep <= 1'b0;
        end else if (state == sfc_pkg::ST_SLEEP_WAIT && dly == 12'h001) begin
            o_deep_sleep <= 1'b1;
        end else if (acc_wake) begin
            o_deep_sleep <= 1'b0;
        end
    end

endmodule // sfc_cmd_engine

// File: verif/sfc_cmd_engine_props.sv
// Checker for the flash command engine, watching its top-level ports only.
// Assumes one core clock; the link pins are watched as levels.
`timescale 1ns/10ps

module sfc_cmd_engine_props (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic o_sio0_oe_n,
    input wire logic o_sio1_oe_n,
    input wire logic o_busy_flag,
    input wire logic o_write_unlock_latch,
    input wire logic o_deep_sleep
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    logic [17:0] busy_len;
    logic [11:0] idle_len;

    // Length of the current busy run
    always_ff @(posedge i_clock) begin
        busy_len <= (o_busy_flag && !i_srst) ? busy_len + 18'h1 : 18'h0;
    end

    // Time chip select has stood high, saturating so it never wraps
    always_ff @(posedge i_clock) begin
        if (i_srst || !i_cs_n) begin
            idle_len <= 12'h0;
        end else if (idle_len != 12'hfff) begin
            idle_len <= idle_len + 12'h1;
        end
    end

    // ------------------------------------------------------------
    // Self-timed cycle and pins
    // ------------------------------------------------------------
    sequence s_cycle_start;
        $rose(o_busy_flag);
    endsequence
    sequence s_cycle_end;
        $fell(o_busy_flag);
    endsequence

    a_reset_clears: assert property (disable iff (1'b0) i_srst |=>
        !o_busy_flag && !o_write_unlock_latch && !o_deep_sleep)
        else $error("state not cleared by reset");
    a_cycle_latch: assert property (s_cycle_start |-> o_write_unlock_latch)
        else $error("cycle started without unlock latch");
    a_cycle_after_cs: assert property (s_cycle_start |-> i_cs_n && $past(i_cs_n))
        else $error("cycle started with chip select low");
    a_cycle_length: assert property (s_cycle_end |->
        busy_len inside {18'h100, 18'h1000, 18'h10000, 18'h20000})
        else $error("busy run has an unexpected length");
    a_cycle_end_latch: assert property (s_cycle_end |-> !o_write_unlock_latch)
        else $error("unlock latch survived the cycle");
    a_busy_no_drive: assert property (o_busy_flag |-> o_sio0_oe_n && o_sio1_oe_n)
        else $error("pins driven during a busy cycle");
    a_dual_pairs: assert property (!o_sio0_oe_n |-> !o_sio1_oe_n)
        else $error("io0 driven without io1");
    a_idle_release: assert property (i_cs_n && $past(i_cs_n) |->
        o_sio0_oe_n && o_sio1_oe_n)
        else $error("pins driven while deselected");
    a_sleep_wait: assert property ($rose(o_deep_sleep) |->
        idle_len >= sfc_pkg::SLEEP_ENTRY_CYC)
        else $error("deep sleep entered too early");
    a_sleep_blocks: assert property (o_deep_sleep |->
        !o_busy_flag && !$rose(o_write_unlock_latch))
        else $error("command executed in deep sleep");
    a_latch_on_cs: assert property ($rose(o_write_unlock_latch) |-> i_cs_n && !o_busy_flag)
        else $error("unlock latch set mid-frame or while busy");
endmodule // sfc_cmd_engine_props

bind sfc_cmd_engine sfc_cmd_engine_props u_sfc_cmd_engine_props (
    .i_clock(i_clock), .i_srst(i_srst), .i_cs_n(i_cs_n),
    .o_sio0_oe_n(o_sio0_oe_n), .o_sio1_oe_n(o_sio1_oe_n), .o_busy_flag(o_busy_flag),
    .o_write_unlock_latch(o_write_unlock_latch), .o_deep_sleep(o_deep_sleep)
);

// File: verif/sfc_host_model.sv
// SPI host model issuing flash frames in mode 0 at a 160 ns bit period.
// Assumes the bench resolves the shared io lines and feeds them back here.
`timescale 1ns/10ps

module sfc_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sio0,
    output logic o_sio1,
    input wire logic i_sio0,
    input wire logic i_sio1,
    input wire logic i_sio0_oe_n,
    input wire logic i_sio1_oe_n
);
    logic drove;

    // Idle: clock low, deselected
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        // One select rise clears the device pins before the first check
        #1;
        o_cs_n = 1'b1;
        o_sio0 = 1'b0;
        o_sio1 = 1'b1;
        drove = 1'b0;
    end

    // One frame: n1 single bits, n2 dual edges, then nrd read units
    task automatic frame(input logic [63:0] tx, input int n1, input int n2,
                         input int nrd, output logic [63:0] rx);
        rx = 64'h0;
        drove = 1'b0;
        #17;
        o_cs_n = 1'b0;
        for (int i = 0; i < n1 + n2; i++) begin
            if (i < n1) begin
                o_sio0 = tx[63 - i];
                o_sio1 = ~o_sio1; // Unused line keeps moving
            end else begin
                {o_sio1, o_sio0} = tx[63 - n1 - 2 * (i - n1) -: 2];
            end
            #80;
            o_sclk = 1'b1;
            #80;
            o_sclk = 1'b0;
        end
        // Released lines toggle so a stale value never passes as data
        for (int i = 0; i < nrd; i++) begin
            o_sio0 = ~o_sio0;
            o_sio1 = ~o_sio1;
            #80;
            rx = (n2 > 0) ? {rx[61:0], i_sio1, i_sio0} : {rx[62:0], i_sio1};
            drove = drove | ~i_sio1_oe_n | ~i_sio0_oe_n;
            o_sclk = 1'b1;
            #80;
            o_sclk = 1'b0;
        end
        #80;
        o_cs_n = 1'b1; // Raised only on a whole unit
        o_sio0 = ~o_sio0;
    endtask
endmodule // sfc_host_model

// File: verif/sfc_cmd_engine_tb_top.sv
// Self-checking bench for the flash command engine with an SPI host model.
// Assumes the checker binds itself; run length stays near 60k clocks.
`timescale 1ns/10ps

module sfc_cmd_engine_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic plh = 1'b0;
    logic pll = 1'b0;
    logic sclk, cs_n, h_sio0, h_sio1, d_sio0, d_sio1, d_oe0_n, d_oe1_n;
    logic busy, latch, sleep;
    logic [63:0] rx;
    int mismatches = 0;
    int cmp_count = 0;
    int c;
    // Shared io lines: the device wins while it drives
    wire sio0_w = d_oe0_n ? h_sio0 : d_sio0;
    wire sio1_w = d_oe1_n ? h_sio1 : d_sio1;

    // Core clock, 4 ns period
    always #2 clk = ~clk;

    sfc_cmd_engine u_sfc_cmd_engine (.i_clock(clk), .i_srst(srst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sio0(sio0_w), .i_sio1(sio1_w), .o_sio0(d_sio0),
        .o_sio0_oe_n(d_oe0_n), .o_sio1(d_sio1), .o_sio1_oe_n(d_oe1_n),
        .i_protect_level_hi(plh), .i_protect_level_lo(pll), .o_busy_flag(busy),
        .o_write_unlock_latch(latch), .o_deep_sleep(sleep));
    sfc_host_model u_sfc_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_sio0(h_sio0),
        .o_sio1(h_sio1), .i_sio0(sio0_w), .i_sio1(sio1_w), .i_sio0_oe_n(d_oe0_n),
        .i_sio1_oe_n(d_oe1_n));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Sampling on the falling edge keeps clear of the update edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_busy(input logic v, input int lim);
        c = 0;
        while (busy !== v) begin
            tick(1);
            c++;
            if (c > lim) begin
                chk(busy, v);
                test_done();
            end
        end
    endtask
    // Chip select stays high long enough for the sync and edge detect
    task automatic fr_raw(input logic [63:0] tx, input int n1, input int n2, input int nrd);
        tick(4);
        u_sfc_host_model.frame(tx, n1, n2, nrd, rx);
    endtask
    task automatic fr(input logic [63:0] tx, input int n1, input int n2, input int nrd);
        fr_raw(tx, n1, n2, nrd);
        tick(4);
    endtask
    task automatic op(input logic [7:0] code, input int n);
        fr({code, 56'h0}, n, 0, 0);
    endtask
    task automatic rd2(input logic [16:0] a, input logic [15:0] exp);
        fr({8'h3b, 7'h0, a, 32'h0}, 8, 16, 8);
        chk(rx[15:0], exp);
    endtask
    task automatic refused;
        tick(8);
        chk(busy, 1'b0);
    endtask
    task automatic set_prot(input logic hi, input logic lo);
        @(posedge clk);
        plh <= hi;
        pll <= lo;
    endtask
    // Unlock, send the frame, then time the self-timed cycle
    task automatic run_cycle(input logic [63:0] tx, input int n1, input int len);
        op(8'h06, 8);
        chk(latch, 1'b1);
        fr_raw(tx, n1, 0, 0);
        wait_busy(1'b1, 8);
        wait_busy(1'b0, 140000);
        chk(c, len);
        chk(latch, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_program;
        chk({busy, latch, sleep, d_oe0_n, d_oe1_n}, 5'h03);
        run_cycle({8'h20, 7'h0, 17'h010a5, 32'h0}, 32, 4096);
        run_cycle({8'h20, 7'h0, 17'h1f123, 32'h0}, 32, 4096);
        run_cycle({8'h20, 24'h0, 32'h0}, 32, 4096);
        run_cycle({8'h02, 7'h0, 17'h010fe, 24'ha1b2c3, 8'h0}, 56, 256);
        run_cycle({8'h02, 7'h0, 17'h1ffff, 8'h5e, 24'h0}, 40, 256);
        run_cycle({8'h02, 24'h0, 8'h3c, 24'h0}, 40, 256);
        rd2(17'h010fe, 16'ha1b2);
        rd2(17'h01000, 16'hc3ff);
        rd2(17'h01ffe, 16'hffff);
        rd2(17'h1ffff, 16'h5e3c);
    endtask
    task automatic t_refuse;
        fr({8'h02, 7'h0, 17'h01010, 32'h0}, 40, 0, 0);
        refused();
        rd2(17'h01010, 16'hffff);
        op(8'h06, 8);
        fr({8'h20, 7'h0, 17'h01000, 32'h0}, 31, 0, 0);
        refused();
        fr({8'h02, 7'h0, 17'h01010, 32'h0}, 36, 0, 0);
        refused();
        set_prot(1'b1, 1'b1);
        fr({8'h20, 24'h0, 32'h0}, 32, 0, 0);
        refused();
        fr({8'h02, 7'h0, 17'h01010, 32'h0}, 40, 0, 0);
        refused();
        set_prot(1'b0, 1'b1);
        op(8'hc7, 8);
        refused();
        fr({8'hd8, 7'h0, 17'h1f000, 32'h0}, 32, 0, 0);
        refused();
        set_prot(1'b0, 1'b0);
        chk(latch, 1'b1);
    endtask
    task automatic t_busy_reads;
        fr_raw({8'h20, 7'h0, 17'h01000, 32'h0}, 32, 0, 0);
        wait_busy(1'b1, 8);
        fr({8'h3b, 56'h0}, 8, 16, 8);
        chk(u_sfc_host_model.drove, 1'b0);
        fr({8'hab, 56'h0}, 32, 0, 16);
        chk(u_sfc_host_model.drove, 1'b0);
        wait_busy(1'b0, 5000);
        chk(latch, 1'b0);
    endtask
    task automatic t_sleep;
        op(8'hb9, 8);
        tick(700);
        chk(sleep, 1'b0);
        tick(60);
        chk(sleep, 1'b1);
        op(8'h06, 8);
        chk(latch, 1'b0);
        fr({8'h3b, 56'h0}, 8, 16, 8);
        chk(u_sfc_host_model.drove, 1'b0);
        op(8'hab, 9);
        chk(sleep, 1'b1);
        fr({8'hab, 56'h0}, 32, 0, 16);
        chk(rx[15:0], {2{sfc_pkg::SIGNATURE}});
        chk(sleep, 1'b0);
        op(8'h06, 8);
        chk(latch, 1'b0);
        tick(sfc_pkg::WAKE_CYC);
        op(8'hb9, 8);
        tick(760);
        op(8'hab, 8);
        chk(sleep, 1'b0);
        tick(sfc_pkg::WAKE_CYC);
        fr({8'hab, 56'h0}, 32, 0, 16);
        op(8'h06, 8);
        chk(latch, 1'b1);
    endtask

    // Reset for two cycles, then the scenarios in order
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        tick(4);
        t_program();
        t_refuse();
        t_busy_reads();
        t_sleep();
        test_done();
    end
endmodule // sfc_cmd_engine_tb_top
